// ---- rtl/nv_store_map.svh ----
// Address, command, pointer and timing constants for the nonvolatile store slave.
`ifndef NV_STORE_MAP_SVH
`define NV_STORE_MAP_SVH
`define SLAVE_ADDR_HI 4'h9
`define PTR_USER_FIRST 8'hA4
`define PTR_USER_LAST 8'hA7
`define PTR_UNDEF_LO 8'hA8
`define PTR_UNDEF_HI 8'hA9
`define PTR_CFG_MSB 8'hAC
`define PTR_LAST 8'hAD
`define CMD_START_CONVERT 8'h51
`define CMD_STOP_CONVERT 8'h22
`define CMD_COPY_DATA 8'h48
`define CMD_RECALL_DATA 8'hB8
`define SHADOW_BASE 8'hA0
`define SHADOW_DEPTH 14
`define CFG_ONE_SHOT_BIT 0
`define CFG_MSB_RESET 8'h00
`define COPY_TIME_NS 10000000
`define CLK_PERIOD_NS 4
`define COPY_CYCLES ((`COPY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- rtl/nv_store_pkg.sv ----
// Types shared by the nonvolatile store slave.
package nv_store_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CTRL,
      ST_PTR,
      ST_DATA,
      ST_IGNORE
   } phase_t;

   typedef struct packed {
      logic converting;
      logic single_conversion_select;
      logic nonvolatile_busy_flag;
   } status_t;
endpackage

// ---- rtl/nv_store_slave.sv ----
// Two-wire slave that stores user bytes to shadow memory and copies them to nonvolatile memory.
`timescale 1ns/1ps
`include "nv_store_map.svh"
module nv_store_slave (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic [2:0] addr_pins_i,
   input wire logic conv_done_i,
   output nv_store_pkg::status_t status_o,
   output logic [7:0] nv_mem_o [`SHADOW_DEPTH]
);
   localparam logic [23:0] COPY_CNT = 24'(`COPY_CYCLES);

   nv_store_pkg::phase_t phase_q, phase_d;
   logic scl_q, sda_q;
   logic [7:0] sh_q [`SHADOW_DEPTH];
   logic [7:0] sh_d [`SHADOW_DEPTH];
   logic [7:0] nv_q [`SHADOW_DEPTH];
   logic [7:0] nv_d [`SHADOW_DEPTH];
   logic [7:0] shift_q, shift_d, ptr_q, ptr_d;
   logic [3:0] bitcnt_q, bitcnt_d;
   // The owed acknowledge (ack_q) goes on the wire (drive_q) only once the clock is low.
   logic ack_q, ack_d, drive_q, drive_d;
   // Set when a run starts with the select bit clear; such a run only ends on a stop command.
   logic cont_q, cont_d;
   logic conv_q, conv_d, oneshot_q, oneshot_d, busy_q, busy_d;
   logic [23:0] copy_q, copy_d;
   logic start_c, stop_c, rise_c, fall_c, writable_c;
   logic [7:0] byte_c;
   logic [3:0] idx_c;

   // Input pins are taken as synchronous, so edges are found from one registered sample.
   assign rise_c = scl_i && !scl_q;
   assign fall_c = !scl_i && scl_q;
   assign start_c = scl_i && scl_q && sda_q && !sda_i;
   assign stop_c = scl_i && scl_q && !sda_q && sda_i;
   assign byte_c = {shift_q[6:0], sda_i};
   assign idx_c = 4'(ptr_q - `SHADOW_BASE);
   // Undefined bytes and any pointer past the last register are refused with a NACK.
   assign writable_c = ptr_q >= `SHADOW_BASE && ptr_q <= `PTR_LAST &&
                       ptr_q != `PTR_UNDEF_LO && ptr_q != `PTR_UNDEF_HI;

   always_comb begin
      phase_d = phase_q;
      shift_d = shift_q;
      ptr_d = ptr_q;
      bitcnt_d = bitcnt_q;
      ack_d = ack_q;
      drive_d = drive_q;
      cont_d = cont_q;
      conv_d = conv_q;
      oneshot_d = oneshot_q;
      busy_d = busy_q;
      copy_d = copy_q;
      sh_d = sh_q;
      nv_d = nv_q;
      // A finished single conversion ends conversions; continuous ones run until stopped.
      if (conv_done_i && conv_q && !cont_q) begin
         conv_d = 1'b0;
      end
      // The copy takes a long fixed time; a master may poll the busy flag instead of waiting.
      if (busy_q) begin
         if (copy_q == 24'h000001) begin
            busy_d = 1'b0;
            nv_d = sh_q;
         end
         copy_d = copy_q - 24'h000001;
      end
      if (start_c) begin
         phase_d = nv_store_pkg::ST_CTRL;
         bitcnt_d = 4'h0;
         ack_d = 1'b0;
         drive_d = 1'b0;
      end else if (stop_c) begin
         phase_d = nv_store_pkg::ST_IDLE;
         ack_d = 1'b0;
         drive_d = 1'b0;
      end else if (fall_c && ack_q) begin
         // Pulling the data line while the clock is high would read as a start or stop.
         if (drive_q) begin
            drive_d = 1'b0;
            ack_d = 1'b0;
            bitcnt_d = 4'h0;
         end else begin
            drive_d = 1'b1;
         end
      end else if (rise_c && phase_q != nv_store_pkg::ST_IDLE && !ack_q) begin
         shift_d = byte_c;
         bitcnt_d = bitcnt_q + 4'h1;
         if (bitcnt_q == 4'h7) begin
            unique case (phase_q)
               nv_store_pkg::ST_CTRL: begin
                  if (byte_c[7:4] == `SLAVE_ADDR_HI && byte_c[3:1] == addr_pins_i &&
                      !byte_c[0]) begin
                     ack_d = 1'b1;
                     phase_d = nv_store_pkg::ST_PTR;
                  end else begin
                     phase_d = nv_store_pkg::ST_IDLE;
                  end
               end
               nv_store_pkg::ST_PTR: begin
                  ack_d = 1'b1;
                  phase_d = nv_store_pkg::ST_DATA;
                  ptr_d = byte_c;
                  unique case (byte_c)
                     `CMD_START_CONVERT: begin
                        conv_d = 1'b1;
                        // A run keeps the mode it started in, whatever the select bit does later.
                        if (!conv_q) begin
                           cont_d = !oneshot_q;
                        end
                     end
                     `CMD_STOP_CONVERT: begin
                        // Only a continuous run is stopped; a single conversion ends by itself.
                        if (cont_q) begin
                           conv_d = 1'b0;
                        end
                     end
                     `CMD_COPY_DATA: begin
                        // Copy is only honoured while converting continuously.
                        if (conv_q && cont_q) begin
                           busy_d = 1'b1;
                           copy_d = COPY_CNT;
                        end
                     end
                     `CMD_RECALL_DATA: begin
                        // Refused during a copy, so the image being written stays whole.
                        if (!busy_q) begin
                           sh_d = nv_q;
                        end
                     end
                     default: ;
                  endcase
               end
               nv_store_pkg::ST_DATA: begin
                  if (writable_c) begin
                     ack_d = 1'b1;
                     sh_d[idx_c] = byte_c;
                     if (ptr_q == `PTR_CFG_MSB) begin
                        oneshot_d = byte_c[`CFG_ONE_SHOT_BIT];
                     end
                     ptr_d = ptr_q + 8'h01;
                  end else begin
                     phase_d = nv_store_pkg::ST_IGNORE;
                  end
               end
               nv_store_pkg::ST_IGNORE: ;
               default: phase_d = nv_store_pkg::ST_IDLE;
            endcase
         end
      end else if (rise_c && phase_q == nv_store_pkg::ST_IGNORE) begin
         bitcnt_d = 4'h0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         phase_q <= nv_store_pkg::ST_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         shift_q <= 8'h00;
         ptr_q <= 8'h00;
         bitcnt_q <= 4'h0;
         ack_q <= 1'b0;
         drive_q <= 1'b0;
         cont_q <= 1'b0;
         conv_q <= 1'b0;
         oneshot_q <= 1'b0;
         busy_q <= 1'b0;
         copy_q <= 24'h000000;
         for (int i = 0; i < `SHADOW_DEPTH; i++) begin
            sh_q[i] <= 8'h00;
            nv_q[i] <= 8'h00;
         end
      end else begin
         phase_q <= phase_d;
         scl_q <= scl_i;
         sda_q <= sda_i;
         shift_q <= shift_d;
         ptr_q <= ptr_d;
         bitcnt_q <= bitcnt_d;
         ack_q <= ack_d;
         drive_q <= drive_d;
         cont_q <= cont_d;
         conv_q <= conv_d;
         oneshot_q <= oneshot_d;
         busy_q <= busy_d;
         copy_q <= copy_d;
         sh_q <= sh_d;
         nv_q <= nv_d;
      end
   end

   // The pin is open drain: the slave only ever pulls low, during its acknowledge bit.
   assign sda_o = 1'b0;
   assign sda_oe_n_o = !drive_q;
   // Status bits come straight from registers, so a master polling them never sees a glitch.
   // The busy flag stays set for the whole copy, and a stop command does not cut the copy short.
   assign status_o.converting = conv_q;
   assign status_o.single_conversion_select = oneshot_q;
   assign status_o.nonvolatile_busy_flag = busy_q;
   assign nv_mem_o = nv_q;
endmodule

// ---- sim/nv_store_chk.sv ----
// Concurrent checks on the ports of the two-wire store slave.
`timescale 1ns/1ps
`include "nv_store_map.svh"
module nv_store_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   input wire nv_store_pkg::status_t status_o,
   input wire logic [7:0] nv_mem_o [`SHADOW_DEPTH]
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Remembers whether the current run began in continuous mode, as the status shows it.
   logic run_cont_q;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         run_cont_q <= 1'b0;
      end else if ($rose(status_o.converting)) begin
         run_cont_q <= !status_o.single_conversion_select;
      end
   end
   property p_od; sda_o == 1'b0; endproperty
   a_od: assert property (p_od) else $error("sda driven high");
   property p_ak; !sda_oe_n_o |-> !sda_i; endproperty
   a_ak: assert property (p_ak) else $error("ack not on wire");
   property p_ft; $fell(sda_oe_n_o) |-> !scl_i; endproperty
   a_ft: assert property (p_ft) else $error("ack began with clock high");
   property p_hd; $fell(sda_oe_n_o) |-> (!sda_oe_n_o) [*8]; endproperty
   a_hd: assert property (p_hd) else $error("ack too short");
   property p_rl; $rose(sda_oe_n_o) |-> !scl_i; endproperty
   a_rl: assert property (p_rl) else $error("ack freed in high");
   property p_cp;
      $rose(status_o.nonvolatile_busy_flag) |-> status_o.converting && run_cont_q;
   endproperty
   a_cp: assert property (p_cp) else $error("copy while idle");
   property p_nv;
      $changed(nv_mem_o[4]) |->
         status_o.nonvolatile_busy_flag || $past(status_o.nonvolatile_busy_flag);
   endproperty
   a_nv: assert property (p_nv) else $error("store changed");
   property p_cv; $rose(status_o.converting) |-> !status_o.nonvolatile_busy_flag; endproperty
   a_cv: assert property (p_cv) else $error("busy at start");
   c_bz: cover property ($rose(status_o.nonvolatile_busy_flag));
   c_ak: cover property ($fell(sda_oe_n_o));
   c_cv: cover property ($rose(status_o.converting));
endmodule
bind nv_store_slave nv_store_chk i_chk (.clk_i, .rst_i, .scl_i, .sda_i, .sda_o,
   .sda_oe_n_o, .status_o, .nv_mem_o);

// ---- sim/nv_bus_master.sv ----
// Behavioural two-wire bus master facing the store slave.
`timescale 1ns/1ps
module nv_bus_master (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o = 1'b1,
   output logic sda_o = 1'b1,
   output logic ack_v_o = 1'b0,
   output logic ack_o = 1'b0
);
   // Outside st and sp, data only moves while the clock is low, so no edge is mistaken for framing.
   task automatic ph(input logic c, input logic d);
      scl_o <= c;
      sda_o <= d;
      repeat (8) @(posedge clk_i);
   endtask
   task automatic st();
      ph(1'b0, sda_o);
      ph(1'b0, 1'b1);
      ph(1'b1, 1'b1);
      ph(1'b1, 1'b0);
   endtask
   task automatic sp();
      ph(1'b0, sda_o);
      ph(1'b0, 1'b0);
      ph(1'b1, 1'b0);
      ph(1'b1, 1'b1);
   endtask
   task automatic byt(input logic [7:0] b);
      logic d;
      for (int i = 8; i >= 0; i--) begin
         d = (i > 0) ? b[i-1] : 1'b1;
         ph(1'b0, sda_o);
         ph(1'b0, d);
         ph(1'b1, d);
      end
      ack_o <= !sda_i;
      ack_v_o <= 1'b1;
      @(posedge clk_i);
      ack_v_o <= 1'b0;
   endtask
endmodule

// ---- sim/nv_store_slave_tb.sv ----
// Self-checking bench for the two-wire store slave.
`timescale 1ns/1ps
`include "nv_store_map.svh"
module nv_store_slave_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [2:0] pins = 3'h0;
   logic [31:0] lf = 32'h1FC8;
   logic [7:0] w;
   logic eq [$];
   logic [7:0] cb [8] = '{`PTR_CFG_MSB, `CMD_START_CONVERT, `PTR_CFG_MSB, `CMD_START_CONVERT,
      `CMD_STOP_CONVERT, `CMD_START_CONVERT, `PTR_CFG_MSB, `CMD_COPY_DATA};
   logic [2:0] es [8] = '{3'h2, 3'h6, 3'h0, 3'h4, 3'h0, 3'h4, 3'h6, 3'h7};
   logic [2:0] ed [8] = '{3'h2, 3'h2, 3'h0, 3'h4, 3'h0, 3'h4, 3'h6, 3'h7};
   logic cdone = 1'b0;
   int num_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   wire logic scl, sda_m, sda_o, oe_n, av, ak;
   wire logic sda = sda_m & (oe_n | sda_o);
   nv_store_pkg::status_t st;
   logic [7:0] nv [`SHADOW_DEPTH];
   always #2 clk_i = ~clk_i;
   nv_store_slave i_dut (.clk_i, .rst_i, .scl_i(scl), .sda_i(sda), .sda_o,
      .sda_oe_n_o(oe_n), .addr_pins_i(pins), .conv_done_i(cdone), .status_o(st), .nv_mem_o(nv));
   nv_bus_master i_mst (.clk_i, .sda_i(sda), .scl_o(scl), .sda_o(sda_m), .ack_v_o(av),
      .ack_o(ak));
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic end_sim;
      $display("errors=%0d checks=%0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic bx(input logic [7:0] b, input logic e);
      eq.push_back(e);
      i_mst.byt(b);
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         end_sim;
      end
   end
   always @(posedge clk_i) if (av) chk({7'h00, ak}, {7'h00, eq.pop_front()});
   initial begin
      repeat (16) @(posedge clk_i);
      lf = nx(lf);
      pins <= lf[2:0];
      rst_i <= 1'b0;
      w = {`SLAVE_ADDR_HI, lf[2:0], 1'b0};
      repeat (4) @(posedge clk_i);
      i_mst.st();
      bx(w, 1'b1);
      bx(`CMD_COPY_DATA, 1'b1);
      i_mst.sp();
      chk({7'h00, st.nonvolatile_busy_flag}, 8'h00);
      i_mst.st();
      bx(w, 1'b1);
      bx(`CMD_RECALL_DATA, 1'b1);
      i_mst.sp();
      i_mst.st();
      bx(w ^ 8'h02, 1'b0);
      i_mst.st();
      bx(w | 8'h01, 1'b0);
      i_mst.st();
      bx(w, 1'b1);
      bx(`PTR_USER_FIRST, 1'b1);
      for (int i = 0; i < 4; i++) begin
         lf = nx(lf);
         bx(lf[7:0], 1'b1);
      end
      // The pointer has now moved onto an undefined byte, which must be refused.
      bx(8'h5A, 1'b0);
      // Single run ended by the converter, continuous run stopped and restarted, then select set and copy.
      for (int i = 0; i < 8; i++) begin
         if (cb[i] == `CMD_STOP_CONVERT) chk({7'h00, st.nonvolatile_busy_flag}, 8'h00);
         i_mst.st();
         bx(w, 1'b1);
         bx(cb[i], 1'b1);
         lf = nx(lf);
         if (cb[i] == `PTR_CFG_MSB) bx({lf[15:9], i != 2}, 1'b1);
         i_mst.sp();
         chk({5'h00, st}, {5'h00, es[i]});
         cdone <= 1'b1;
         @(posedge clk_i);
         cdone <= 1'b0;
         @(posedge clk_i);
         chk({5'h00, st}, {5'h00, ed[i]});
      end
      // The copy outlasts the bench, so the stored image must not have moved yet.
      chk(nv[4], 8'h00);
      repeat (8) @(posedge clk_i);
      end_sim;
   end
endmodule
